// file: logic/sbgp_port.sv
// six-bit general-purpose port with register file and pad control
// Function
// - input pins read back sampled pin level
// - output pins read back the data latch
// - writes update every latch bit always
// - output pins drive their latch value
// - reset clears latch, pins become inputs
// - direction bit chooses input or output
// - pullup bit enables pullup for inputs
// - outputs ignore pullup bit, pullup off
// - slew bit limits outputs, no input effect
// - drive bit selects high or low drive
//
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module sbgp_port (
  input  wire logic                         clk,
  input  wire logic                         resetn,
  input  wire logic [sbgp_pkg::ADDR_W-1:0]  addr,
  input  wire logic [sbgp_pkg::DATA_W-1:0]  wdata,
  input  wire logic                         wr,
  input  wire logic                         rd,
  output logic      [sbgp_pkg::DATA_W-1:0]  rdata,
  input  wire logic [sbgp_pkg::PIN_W-1:0]   pin_in,
  output logic      [sbgp_pkg::PIN_W-1:0]   pin_out,
  output logic      [sbgp_pkg::PIN_W-1:0]   pin_oe,
  output logic      [sbgp_pkg::PIN_W-1:0]   pullup_on,
  output logic      [sbgp_pkg::PIN_W-1:0]   slew_on,
  output logic      [sbgp_pkg::PIN_W-1:0]   drive_high
);
  import sbgp_pkg::*;

  logic [PIN_W-1:0]  port_output_data;
  logic [PIN_W-1:0]  port_direction;
  logic [PIN_W-1:0]  port_pullup_enable;
  logic [PIN_W-1:0]  port_slew_enable;
  logic [PIN_W-1:0]  port_drive_strength;
  logic [PIN_W-1:0]  read_bits;
  logic [DATA_W-1:0] next_rdata;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // only bits 5:0 are stored, bits 7:6 discarded
  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_output_data <= RST_OUTPUT_DATA;
    end else if (wr && hit(addr, OFS_OUTPUT_DATA)) begin
      port_output_data <= wdata[PIN_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_direction <= RST_DIRECTION;
    end else if (wr && hit(addr, OFS_DIRECTION)) begin
      port_direction <= wdata[PIN_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_pullup_enable <= RST_PULLUP_ENABLE;
    end else if (wr && hit(addr, OFS_PULLUP_ENABLE)) begin
      port_pullup_enable <= wdata[PIN_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_slew_enable <= RST_SLEW_ENABLE;
    end else if (wr && hit(addr, OFS_SLEW_ENABLE)) begin
      port_slew_enable <= wdata[PIN_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_drive_strength <= RST_DRIVE_STRENGTH;
    end else if (wr && hit(addr, OFS_DRIVE_STRENGTH)) begin
      port_drive_strength <= wdata[PIN_W-1:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_pin
      sbgp_pin_cell u_cell (
        .latch      (port_output_data[gi]),
        .dir        (port_direction[gi]),
        .pullup_en  (port_pullup_enable[gi]),
        .slew_en    (port_slew_enable[gi]),
        .drive_hi   (port_drive_strength[gi]),
        .pin_in     (pin_in[gi]),
        .pin_out    (pin_out[gi]),
        .pin_oe     (pin_oe[gi]),
        .pullup_on  (pullup_on[gi]),
        .slew_on    (slew_on[gi]),
        .drive_high (drive_high[gi]),
        .read_bit   (read_bits[gi])
      );
    end
  endgenerate

  // read mux, upper bits always zero
  always_comb begin
    next_rdata = UNMAPPED_READ;
    if (rd) begin
      unique case (addr)
        OFS_OUTPUT_DATA:    next_rdata = {2'h0, read_bits};
        OFS_DIRECTION:      next_rdata = {2'h0, port_direction};
        OFS_PULLUP_ENABLE:  next_rdata = {2'h0, port_pullup_enable};
        OFS_SLEW_ENABLE:    next_rdata = {2'h0, port_slew_enable};
        OFS_DRIVE_STRENGTH: next_rdata = {2'h0, port_drive_strength};
        default:            next_rdata = UNMAPPED_READ;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata <= UNMAPPED_READ;
    end else begin
      rdata <= next_rdata;
    end
  end

  // reset state
  reset_hiz_a: assert property (
    @(posedge clk)
    $past(!resetn) |->
      (pin_oe == 6'h00 && pullup_on == 6'h00
       && port_output_data == RST_OUTPUT_DATA))
    else $error("pins not released to inputs after reset");

  ctrl_reset_a: assert property (
    @(posedge clk)
    $past(!resetn) |->
      (port_direction == RST_DIRECTION
       && port_pullup_enable == RST_PULLUP_ENABLE
       && port_slew_enable == RST_SLEW_ENABLE
       && port_drive_strength == RST_DRIVE_STRENGTH
       && slew_on == 6'h00 && drive_high == 6'h00))
    else $error("control registers not cleared by reset");

  // register writes and holds
  data_write_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr && addr == OFS_OUTPUT_DATA) |=>
      (port_output_data == $past(wdata[5:0])
       && pin_out == $past(wdata[5:0])))
    else $error("data latch not updated by write");

  data_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == OFS_OUTPUT_DATA) |=> $stable(port_output_data))
    else $error("data latch changed without a write");

  drive_latch_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr && addr == OFS_DIRECTION) |=>
      (pin_oe == $past(wdata[5:0])
       && pin_out == $past(port_output_data)))
    else $error("direction write not reflected on driver");

  dir_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == OFS_DIRECTION) |=> $stable(port_direction))
    else $error("direction changed without a write");

  pullup_set_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr && addr == OFS_PULLUP_ENABLE) |=>
      (pullup_on == ($past(wdata[5:0]) & ~pin_oe)))
    else $error("pullup enable not applied");

  pullup_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == OFS_PULLUP_ENABLE) |=> $stable(port_pullup_enable))
    else $error("pullup enable changed without a write");

  slew_gate_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr && addr == OFS_SLEW_ENABLE) |=>
      (slew_on == ($past(wdata[5:0]) & pin_oe)))
    else $error("slew control not gated by direction");

  slew_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == OFS_SLEW_ENABLE) |=> $stable(port_slew_enable))
    else $error("slew enable changed without a write");

  drive_set_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr && addr == OFS_DRIVE_STRENGTH) |=>
      (drive_high == $past(wdata[5:0])))
    else $error("drive strength not applied");

  drive_hold_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !(wr && addr == OFS_DRIVE_STRENGTH) |=> $stable(port_drive_strength))
    else $error("drive strength changed without a write");

  unmapped_wr_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (wr && addr > OFS_DRIVE_STRENGTH) |=>
      ($stable(port_output_data) && $stable(port_direction)
       && $stable(port_pullup_enable) && $stable(port_slew_enable)
       && $stable(port_drive_strength)))
    else $error("write to unmapped index changed state");

  // pad gating, driver and drive select per pin, and per-pin read source
  pullup_gate_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (pullup_on & pin_oe) == 6'h00)
    else $error("pullup on while driving");

  slew_input_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (slew_on & ~pin_oe) == 6'h00)
    else $error("slew limiting on an input pin");

  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_chk
      data_drive_a: assert property (
        @(posedge clk) disable iff (!resetn)
        pin_oe[gi] |-> (pin_out[gi] == port_output_data[gi]))
        else $error("output pin not driven from its latch");

      pullup_pin_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (!pin_oe[gi] && port_pullup_enable[gi]) |-> pullup_on[gi])
        else $error("enabled pullup off on an input pin");

      slew_pin_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (pin_oe[gi] && port_slew_enable[gi]) |-> slew_on[gi])
        else $error("enabled slew limiting off on an output pin");

      drive_pin_a: assert property (
        @(posedge clk) disable iff (!resetn)
        drive_high[gi] == port_drive_strength[gi])
        else $error("drive selection differs from its bit");

      pin_read_a: assert property (
        @(posedge clk) disable iff (!resetn)
        (rd && addr == OFS_OUTPUT_DATA) |=>
          (rdata[gi] == ($past(port_direction[gi])
                         ? $past(port_output_data[gi])
                         : $past(pin_in[gi]))))
        else $error("data read took the wrong source for a pin");
    end
  endgenerate

  // register reads
  read_input_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && addr == OFS_OUTPUT_DATA) |=>
      ((rdata[5:0] & ~$past(port_direction))
       == ($past(pin_in) & ~$past(port_direction))))
    else $error("input pin level not returned");

  read_latch_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && addr == OFS_OUTPUT_DATA) |=>
      ((rdata[5:0] & $past(port_direction))
       == ($past(port_output_data) & $past(port_direction))))
    else $error("output latch not returned");

  dir_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && addr == OFS_DIRECTION) |=>
      (rdata == {2'h0, $past(port_direction)}))
    else $error("direction register not read back");

  pullup_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && addr == OFS_PULLUP_ENABLE) |=>
      (rdata == {2'h0, $past(port_pullup_enable)}))
    else $error("pullup enable register not read back");

  slew_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && addr == OFS_SLEW_ENABLE) |=>
      (rdata == {2'h0, $past(port_slew_enable)}))
    else $error("slew enable register not read back");

  drive_read_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && addr == OFS_DRIVE_STRENGTH) |=>
      (rdata == {2'h0, $past(port_drive_strength)}))
    else $error("drive strength register not read back");

  unmapped_rd_a: assert property (
    @(posedge clk) disable iff (!resetn)
    (rd && addr > OFS_DRIVE_STRENGTH) |=>
      (rdata == UNMAPPED_READ))
    else $error("unmapped index read nonzero");

  rdata_idle_a: assert property (
    @(posedge clk) disable iff (!resetn)
    !rd |=> (rdata == UNMAPPED_READ))
    else $error("read data nonzero outside a read slot");

  upper_zero_a: assert property (
    @(posedge clk) disable iff (!resetn)
    rdata[7:6] == 2'h0)
    else $error("reserved bits read nonzero");
endmodule : sbgp_port

// file: logic/sbgp_pkg.sv
// package: register map, widths and reset values of the six-bit port
package sbgp_pkg;
  localparam int unsigned PIN_W  = 6;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 3;

  localparam logic [ADDR_W-1:0] OFS_OUTPUT_DATA    = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_DIRECTION      = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_PULLUP_ENABLE  = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_SLEW_ENABLE    = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_DRIVE_STRENGTH = 3'h4;

  localparam logic [PIN_W-1:0] RST_OUTPUT_DATA    = 6'h00;
  localparam logic [PIN_W-1:0] RST_DIRECTION      = 6'h00;
  localparam logic [PIN_W-1:0] RST_PULLUP_ENABLE  = 6'h00;
  localparam logic [PIN_W-1:0] RST_SLEW_ENABLE    = 6'h00;
  localparam logic [PIN_W-1:0] RST_DRIVE_STRENGTH = 6'h00;

  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
endpackage : sbgp_pkg

// file: logic/sbgp_pin_cell.sv
// per-pin pad control: driver, pullup and slew gating, drive select passed straight through
`timescale 1ns/1ps
module sbgp_pin_cell (
  input  wire logic latch,
  input  wire logic dir,
  input  wire logic pullup_en,
  input  wire logic slew_en,
  input  wire logic drive_hi,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pullup_on,
  output logic      slew_on,
  output logic      drive_high,
  output logic      read_bit
);
  assign pin_oe     = dir;
  assign pin_out    = latch;
  assign pullup_on  = pullup_en & ~dir;
  assign slew_on    = slew_en & dir;
  assign drive_high = drive_hi;
  assign read_bit   = dir ? latch : pin_in;
endmodule : sbgp_pin_cell

// file: tb/sbgp_pin_model.sv
// pad model: external drivers, pullups and floating pins
`timescale 1ns/1ps
module sbgp_pin_model (
  input  wire logic                       clk,
  input  wire logic [sbgp_pkg::PIN_W-1:0] pin_out,
  input  wire logic [sbgp_pkg::PIN_W-1:0] pin_oe,
  input  wire logic [sbgp_pkg::PIN_W-1:0] pullup_on,
  input  wire logic [sbgp_pkg::PIN_W-1:0] ext_val,
  input  wire logic [sbgp_pkg::PIN_W-1:0] ext_en,
  output logic      [sbgp_pkg::PIN_W-1:0] pin_in
);
  import sbgp_pkg::*;
  logic [PIN_W-1:0] flt = 6'h00;
  // a floating pin toggles every cycle so it is never a steady level
  always @(posedge clk) begin
    flt <= ~flt;
  end
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                | (~pin_oe & ~ext_en & (pullup_on | flt));
endmodule : sbgp_pin_model

// file: tb/tb_top.sv
// testbench: random register traffic, pin checks, queued read-back
`timescale 1ns/1ps
module tb_top;
  import sbgp_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_d = 1'b0;
  logic [7:0]  rdata;
  logic [5:0]  pin_in, pin_out, pin_oe, pullup_on, slew_on, drive_high;
  logic [5:0]  ext_val = 6'h00;
  logic [5:0]  ext_en = 6'h3F;
  logic [5:0]  lat, dir, pe, se, ds, lvl;
  logic [31:0] seed = 32'h80E265BD;
  logic [31:0] r;
  logic [7:0]  exp_q[$];
  int          err_count = 0;
  int          n_checks = 0;
  always #50 clk = ~clk;
  sbgp_port uut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pullup_on(pullup_on), .slew_on(slew_on),
    .drive_high(drive_high));
  sbgp_pin_model pads (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pullup_on(pullup_on), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pin_in));
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task test_done();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  // result watcher: read data stand only in the cycle after the strobe
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) chk(rdata, exp_q.pop_front());
    else chk(rdata, 8'h00);
  end
  task chk_pins();
    @(negedge clk);
    chk({2'b00, pin_oe}, {2'b00, dir});
    chk({2'b00, pin_out}, {2'b00, lat});
    chk({2'b00, pullup_on}, {2'b00, pe & ~dir});
    chk({2'b00, slew_on}, {2'b00, se & dir});
    chk({2'b00, drive_high}, {2'b00, ds});
  endtask : chk_pins
  task rd_all();
    lvl = (ext_en & ext_val) | ~ext_en;
    rd_reg(OFS_OUTPUT_DATA,
           {2'b00, (dir & lat) | (~dir & lvl)});
    rd_reg(OFS_DIRECTION, {2'b00, dir});
    rd_reg(OFS_PULLUP_ENABLE, {2'b00, pe});
    rd_reg(OFS_SLEW_ENABLE, {2'b00, se});
    rd_reg(OFS_DRIVE_STRENGTH, {2'b00, ds});
    for (int a = 5; a < 8; a++) rd_reg(3'(a), 8'h00);
  endtask : rd_all
  task do_reset();
    ext_val <= 6'h00;
    ext_en <= 6'h3F;
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    {lat, dir, pe, se, ds} = '0;
  endtask : do_reset
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end
  initial begin
    do_reset();
    chk_pins();
    rd_all();
    for (int i = 0; i < 24; i++) begin
      r = xs();
      {ds, se, pe, dir, lat} = r[29:0];
      wr_reg(OFS_OUTPUT_DATA, {r[30], 1'b0, lat});
      wr_reg(OFS_DIRECTION, {r[31], 1'b0, dir});
      wr_reg(OFS_PULLUP_ENABLE, {r[6], 1'b0, pe});
      wr_reg(OFS_SLEW_ENABLE, {r[9], 1'b0, se});
      wr_reg(OFS_DRIVE_STRENGTH, {r[2], 1'b0, ds});
      wr_reg(3'(5 + i % 3), r[7:0] & 8'hBF);
      r = xs();
      ext_val <= r[5:0];
      ext_en <= r[11:6] | pe;
      chk_pins();
      rd_all();
    end
    do_reset();
    chk_pins();
    rd_all();
    test_done();
  end
endmodule : tb_top
